// ---- logic/sfrw_core.sv ----
// Register write command interpreter of one stacked serial flash die.
`timescale 1ns/10ps
module sfrw_core #(
	parameter int TW_CYCLES = sfrw_pkg::TW_CYC,
	parameter int TNVCR_CYCLES = sfrw_pkg::TNVCR_CYC
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic nrst,
	// Serial link pins, all asynchronous to ref_clk.
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic [3:0] dq_in,
	input wire logic wp_n,
	// Protocol mode and write enable commands from the same clock.
	input wire logic [1:0] proto_mode,
	input wire logic wren_set,
	input wire logic wren_clr,
	// Register contents and status.
	output sfrw_pkg::sfrw_regs_t regs,
	output logic pe_ready,
	output logic hw_locked,
	output logic cmd_done
);

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------

	// Bits taken per clock edge in each protocol mode.
	function automatic logic [4:0] lane_bits(input logic [1:0] mode);
		logic [4:0] n;
		n = 5'h01;
		if (mode == sfrw_pkg::MODE_DUAL) begin
			n = 5'h02;
		end else if (mode == sfrw_pkg::MODE_QUAD) begin
			n = 5'h04;
		end
		return n;
	endfunction

	// Shifts new bits in at the bottom, the highest line first.
	function automatic logic [23:0] shift_in(input logic [23:0] sh,
		input logic [3:0] d, input logic [1:0] mode);
		logic [23:0] r;
		r = {sh[22:0], d[0]};
		if (mode == sfrw_pkg::MODE_DUAL) begin
			r = {sh[21:0], d[1:0]};
		end else if (mode == sfrw_pkg::MODE_QUAD) begin
			r = {sh[19:0], d[3:0]};
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic [1:0] rst_sync_q;
	logic rst_n;

	// Releases the reset two clock edges after nrst rises.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// ----------------------------------------------------------------
	// Pin synchronisers and edge detection
	// ----------------------------------------------------------------
	sfrw_pkg::sfrw_pins_t pins_meta_q;
	sfrw_pkg::sfrw_pins_t pins_q;
	sfrw_pkg::sfrw_pins_t pins_prev_q;
	sfrw_pkg::sfrw_pins_t pins_raw;
	logic sclk_rise;
	logic cs_rise;
	logic cs_fall;

	assign pins_raw = '{sclk: sclk, cs_n: cs_n, dq: dq_in, wp_n: wp_n};

	// Two stages on every pin, a third copy for edge finding.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pins_meta_q <= '{sclk: 1'b0, cs_n: 1'b1, dq: 4'h0, wp_n: 1'b1};
			pins_q <= '{sclk: 1'b0, cs_n: 1'b1, dq: 4'h0, wp_n: 1'b1};
			pins_prev_q <= '{sclk: 1'b0, cs_n: 1'b1, dq: 4'h0, wp_n: 1'b1};
		end else begin
			pins_meta_q <= pins_raw;
			pins_q <= pins_meta_q;
			pins_prev_q <= pins_q;
		end
	end

	// Data is taken on the rising serial clock while selected.
	assign sclk_rise = pins_q.sclk & ~pins_prev_q.sclk & ~pins_q.cs_n;
	assign cs_rise = pins_q.cs_n & ~pins_prev_q.cs_n;
	assign cs_fall = ~pins_q.cs_n & pins_prev_q.cs_n;

	// ----------------------------------------------------------------
	// Frame capture
	// ----------------------------------------------------------------
	logic [23:0] shift_q;
	logic [23:0] shift_d;
	logic [4:0] bits_q;
	logic [4:0] bits_d;
	logic [5:0] bits_sum;
	logic [7:0] opcode_q;

	assign bits_sum = {1'b0, bits_q} + {1'b0, lane_bits(proto_mode)};
	assign shift_d = shift_in(shift_q, pins_q.dq, proto_mode);

	// Counts bits, saturating so overlong frames never look valid.
	always_comb begin
		bits_d = bits_q;
		if (cs_fall) begin
			bits_d = 5'h00;
		end else if (sclk_rise) begin
			bits_d = bits_sum[5] ? sfrw_pkg::BITS_MAX : bits_sum[4:0];
		end
	end

	// Collects command and data bits on the mode's lines.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			shift_q <= 24'h000000;
			bits_q <= 5'h00;
			opcode_q <= 8'h00;
		end else begin
			bits_q <= bits_d;
			if (sclk_rise) begin
				shift_q <= shift_d;
			end
			if (sclk_rise && bits_d == sfrw_pkg::BITS_OPCODE) begin
				opcode_q <= shift_d[7:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Command decode at the end of a frame
	// ----------------------------------------------------------------
	sfrw_pkg::sfrw_state_t state_q;
	sfrw_pkg::sfrw_state_t state_d;
	logic [5:0] sr_hi_q;
	logic [15:0] nvcr_q;
	logic [7:0] vcr_q;
	logic [7:0] evcr_q;
	logic [7:0] ear_q;
	localparam int TIMER_W_L = sfrw_pkg::TIMER_W;
	logic [15:0] pend_q;
	logic [TIMER_W_L-1:0] timer_q;
	logic wel_q;
	logic done_q;
	logic idle;
	logic one_byte;
	logic two_byte;
	logic accept;
	logic do_wsr;
	logic do_wnv;
	logic do_vcr;
	logic do_evcr;
	logic do_ear;
	logic sr_locked;
	logic timer_end;
	logic finish;
	logic [7:0] vcr_new;

	assign idle = state_q == sfrw_pkg::ST_IDLE;
	// Frames that stop off the byte boundary are dropped.
	assign one_byte = bits_q == sfrw_pkg::BITS_ONE_BYTE;
	assign two_byte = bits_q == sfrw_pkg::BITS_TWO_BYTE;
	// Nothing is done without the write enable latch set.
	assign accept = cs_rise & wel_q & idle;
	assign do_wsr = accept & one_byte & opcode_q == sfrw_pkg::OP_WR_SR;
	assign do_wnv = accept & two_byte & opcode_q == sfrw_pkg::OP_WR_NVCR;
	assign do_vcr = accept & one_byte & opcode_q == sfrw_pkg::OP_WR_VCR;
	assign do_evcr = accept & one_byte &
		opcode_q == sfrw_pkg::OP_WR_EVCR;
	assign do_ear = accept & one_byte &
		opcode_q == sfrw_pkg::OP_WR_EAR;

	// Lock bit with the protect pin low bars status changes.
	assign sr_locked = sr_hi_q[sfrw_pkg::SR_LOCK_POS] & ~pins_q.wp_n;
	// Reserved positions keep their old value.
	assign vcr_new = (shift_q[7:0] & ~sfrw_pkg::VCR_RSVD_MASK) |
		(vcr_q & sfrw_pkg::VCR_RSVD_MASK);

	assign timer_end = timer_q == '0;
	assign finish = ~idle & timer_end;

	// Self-timed sequence for the two nonvolatile writes.
	always_comb begin
		state_d = state_q;
		case (state_q)
			sfrw_pkg::ST_IDLE: begin
				if (do_wsr) begin
					state_d = sfrw_pkg::ST_WSR;
				end else if (do_wnv) begin
					state_d = sfrw_pkg::ST_WNV;
				end
			end
			sfrw_pkg::ST_WSR: begin
				if (timer_end) begin
					state_d = sfrw_pkg::ST_IDLE;
				end
			end
			sfrw_pkg::ST_WNV: begin
				if (timer_end) begin
					state_d = sfrw_pkg::ST_IDLE;
				end
			end
			default: begin
				state_d = sfrw_pkg::ST_IDLE;
			end
		endcase
	end

	// State, duration timer and captured write data.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= sfrw_pkg::ST_IDLE;
			timer_q <= '0;
			pend_q <= 16'h0000;
		end else begin
			state_q <= state_d;
			if (do_wsr) begin
				timer_q <= TIMER_W_L'(TW_CYCLES - 1);
				pend_q <= {8'h00, shift_q[7:0]};
			end else if (do_wnv) begin
				timer_q <= TIMER_W_L'(TNVCR_CYCLES - 1);
				// First byte received is the low byte.
				pend_q <= {shift_q[7:0], shift_q[15:8]};
			end else if (!timer_end) begin
				timer_q <= timer_q - 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Register updates
	// ----------------------------------------------------------------

	// Nonvolatile values land when the timed write ends.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sr_hi_q <= sfrw_pkg::SR_HI_RST;
			nvcr_q <= sfrw_pkg::NVCR_RST;
		end else begin
			if (finish && state_q == sfrw_pkg::ST_WSR && !sr_locked) begin
				sr_hi_q <= pend_q[7:2];
			end
			if (finish && state_q == sfrw_pkg::ST_WNV) begin
				nvcr_q <= pend_q;
			end
		end
	end

	// Volatile registers change at once, with no busy time.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			vcr_q <= sfrw_pkg::VCR_RST;
			evcr_q <= sfrw_pkg::EVCR_RST;
			ear_q <= sfrw_pkg::EAR_RST;
		end else begin
			if (do_vcr) begin
				vcr_q <= vcr_new;
			end
			if (do_evcr) begin
				evcr_q <= shift_q[7:0];
			end
			if (do_ear) begin
				ear_q <= shift_q[7:0];
			end
		end
	end

	// Latch clears at the end of a timed write; a set wins.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wel_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			if (wren_set) begin
				wel_q <= 1'b1;
			end else if (finish || wren_clr) begin
				wel_q <= 1'b0;
			end
			done_q <= finish | do_vcr | do_evcr | do_ear;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------

	// Busy while timed, never for volatile writes.
	assign regs = '{sr: {sr_hi_q, wel_q, ~idle}, nvcr: nvcr_q,
		vcr: vcr_q, evcr: evcr_q, ear: ear_q};
	// This die's controller flag reads 1 once it is idle.
	assign pe_ready = idle;
	assign hw_locked = sr_locked;
	assign cmd_done = done_q;

endmodule

// ---- logic/sfrw_pkg.sv ----
// Constants, types and states for the register write command interpreter.
// Summary of operation
// - Status write loads status bits 7 to 2.
// - Status write keeps status bits 1 and 0.
// - Lock bit plus write-protect pin blocks status writes.
// - Write-in-progress is 1 during nonvolatile writes.
// - Write enable latch clears after nonvolatile writes.
// - Write-in-progress returns to 0 when finished.
// - Each die reports controller ready 1 when done.
// - Volatile configuration write takes effect at once.
// - Volatile write keeps reserved bits unchanged.
// - Opcode 61h writes enhanced volatile configuration.
// - Opcode C5h writes extended address register.
// - Chip select must rise on byte boundary.
// - Nonvolatile writes are self-timed after select rises.
// - One, two or four data lines per mode.
package sfrw_pkg;

	// ----------------------------------------------------------------
	// Command codes and protocol modes
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_WR_SR = 8'h01;
	localparam logic [7:0] OP_WR_NVCR = 8'hB1;
	localparam logic [7:0] OP_WR_VCR = 8'h81;
	localparam logic [7:0] OP_WR_EVCR = 8'h61;
	localparam logic [7:0] OP_WR_EAR = 8'hC5;
	localparam logic [1:0] MODE_EXT = 2'h0;
	localparam logic [1:0] MODE_DUAL = 2'h1;
	localparam logic [1:0] MODE_QUAD = 2'h2;

	// ----------------------------------------------------------------
	// Frame lengths in bits, command byte included
	// ----------------------------------------------------------------
	localparam logic [4:0] BITS_OPCODE = 5'h08;
	localparam logic [4:0] BITS_ONE_BYTE = 5'h10;
	localparam logic [4:0] BITS_TWO_BYTE = 5'h18;
	localparam logic [4:0] BITS_MAX = 5'h1F;

	// ----------------------------------------------------------------
	// Field positions, masks and reset values
	// ----------------------------------------------------------------
	localparam int SR_LOCK_POS = 5;
	localparam logic [7:0] VCR_RSVD_MASK = 8'h04;
	localparam logic [5:0] SR_HI_RST = 6'h00;
	localparam logic [15:0] NVCR_RST = 16'hFFFF;
	localparam logic [7:0] VCR_RST = 8'hFB;
	localparam logic [7:0] EVCR_RST = 8'hDF;
	localparam logic [7:0] EAR_RST = 8'h00;

	// ----------------------------------------------------------------
	// Self-timed write durations
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 8;
	localparam int T_W_NS = 1000000;
	localparam int T_NVCR_NS = 1000000;
	localparam int TW_CYC = (T_W_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TNVCR_CYC =
		(T_NVCR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TIMER_W = 24;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic sclk;
		logic cs_n;
		logic [3:0] dq;
		logic wp_n;
	} sfrw_pins_t;

	typedef struct packed {
		logic [7:0] sr;
		logic [15:0] nvcr;
		logic [7:0] vcr;
		logic [7:0] evcr;
		logic [7:0] ear;
	} sfrw_regs_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_WSR = 3'h2,
		ST_WNV = 3'h4
	} sfrw_state_t;

endpackage

// ---- tb/sfrw_checker.sv ----
// Port assertions for the register write command interpreter.
`timescale 1ns/10ps
module sfrw_checker (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic nrst,
	// Observed pin and results.
	input wire logic wp_n,
	input wire sfrw_pkg::sfrw_regs_t regs,
	input wire logic pe_ready,
	input wire logic hw_locked,
	input wire logic cmd_done
);
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	// All checks sample on the system clock and sleep during reset.
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	a_busy_not_ready: assert property (regs.sr[0] |-> !pe_ready)
		else $error("controller ready shown while busy");
	a_busy_min_len: assert property ($rose(regs.sr[0]) |->
		regs.sr[0] [*8])
		else $error("busy period ended too soon");
	a_lock_cause: assert property (hw_locked |->
		regs.sr[7] && !$past(wp_n, 2))
		else $error("lock shown without lock bit and low pin");
	a_end_done: assert property ($fell(regs.sr[0]) |-> cmd_done)
		else $error("no done pulse after timed write");
	a_end_latch_clr: assert property ($fell(regs.sr[0]) |->
		!regs.sr[1])
		else $error("latch still set after timed write");
	a_vol_at_once: assert property (($changed(regs.vcr) ||
		$changed(regs.evcr) || $changed(regs.ear)) |->
		!regs.sr[0] && cmd_done)
		else $error("volatile write not immediate");
	a_start_needs_wel: assert property ($fell(pe_ready) |->
		regs.sr[0] && $past(regs.sr[1]))
		else $error("timed write started without latch set");
	a_rsvd_kept: assert property ($changed(regs.vcr) |->
		regs.vcr[2] == $past(regs.vcr[2]))
		else $error("reserved configuration bit changed");
	a_sr_at_end: assert property ($changed(regs.sr[7:2]) |->
		$fell(regs.sr[0]))
		else $error("status bits changed outside timed end");
endmodule

bind sfrw_core sfrw_checker sfrw_checker_i (.ref_clk(ref_clk), .nrst(nrst),
	.wp_n(wp_n), .regs(regs), .pe_ready(pe_ready), .hw_locked(hw_locked),
	.cmd_done(cmd_done));

// ---- tb/sfrw_host.sv ----
// Host controller model that frames register write commands on the link.
`timescale 1ns/10ps
module sfrw_host (
	// Link pins toward the device.
	output logic sclk,
	output logic cs_n,
	output logic [3:0] dq
);
	// The link idles deselected with its clock standing low.
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		dq = 4'hA;
	end

	// Shifts n bits MSB first, one, two or four lines a beat, then deselects.
	task automatic send(input logic [1:0] m, input int n,
		input logic [23:0] d);
		int w;
		w = (m == 2'h0) ? 1 : (m == 2'h1) ? 2 : 4;
		cs_n = 1'b0;
		for (int i = n - w; i >= 0; i = i - w) begin
			dq = 4'(d >> i);
			#62.5 sclk = 1'b1;
			#62.5 sclk = 1'b0;
		end
		#62.5 cs_n = 1'b1;
		dq = ~dq;
	endtask
endmodule

// ---- tb/tb_top.sv ----
// Self-checking testbench for the register write command interpreter.
`timescale 1ns/10ps
module tb_top;
	localparam logic [7:0] VEXP = (8'h0F & ~sfrw_pkg::VCR_RSVD_MASK) |
		(sfrw_pkg::VCR_RST & sfrw_pkg::VCR_RSVD_MASK);
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic wp_n = 1'b1;
	logic [1:0] proto_mode = 2'h0;
	logic wren_set = 1'b0;
	logic wren_clr = 1'b0;
	logic sclk, cs_n, pe_ready, hw_locked, cmd_done, dn, bsy;
	logic [3:0] dq;
	sfrw_pkg::sfrw_regs_t regs;
	int errors = 0;
	int cmp_count = 0;

	// The system clock toggles every half period.
	always #4 ref_clk = ~ref_clk;

	sfrw_core #(.TW_CYCLES(20), .TNVCR_CYCLES(20)) sfrw_core_i (
		.ref_clk(ref_clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n),
		.dq_in(dq), .wp_n(wp_n), .proto_mode(proto_mode),
		.wren_set(wren_set), .wren_clr(wren_clr), .regs(regs),
		.pe_ready(pe_ready), .hw_locked(hw_locked), .cmd_done(cmd_done));
	sfrw_host sfrw_host_i (.sclk(sclk), .cs_n(cs_n), .dq(dq));

	task automatic check(input string nm, input logic [15:0] seen,
		input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Sets or clears the latch, sends a frame, waits a bounded time for done.
	task automatic wr(input logic en, input logic [1:0] m, input int n,
		input logic [23:0] d);
		@(negedge ref_clk);
		proto_mode = m;
		wren_set = en;
		wren_clr = ~en;
		@(negedge ref_clk);
		wren_set = 1'b0;
		wren_clr = 1'b0;
		sfrw_host_i.send(m, n, d);
		dn = 1'b0;
		bsy = 1'b0;
		for (int i = 0; i < 60 && dn == 1'b0; i++) begin
			@(negedge ref_clk);
			bsy = bsy | (regs.sr[0] === 1'b1 && pe_ready === 1'b0);
			dn = (cmd_done === 1'b1);
		end
		@(negedge ref_clk);
	endtask

	task automatic results;
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Main sequence of register write tests.
	initial begin
		repeat (16) @(negedge ref_clk);
		nrst = 1'b1;
		repeat (6) @(negedge ref_clk);
		wr(1'b1, sfrw_pkg::MODE_EXT, 16, {8'h00, sfrw_pkg::OP_WR_VCR, 8'h0F});
		check("vcr", 16'({dn, regs.vcr}), 16'({1'b1, VEXP}));
		check("vcr_busy", 16'(bsy), 16'h0000);
		wr(1'b1, sfrw_pkg::MODE_DUAL, 16, {8'h00, sfrw_pkg::OP_WR_EVCR, 8'h5A});
		check("evcr", 16'(regs.evcr), 16'h005A);
		wr(1'b1, sfrw_pkg::MODE_QUAD, 16, {8'h00, sfrw_pkg::OP_WR_EAR, 8'hA5});
		check("ear", 16'(regs.ear), 16'h00A5);
		$display("test volatile writes done");
		wr(1'b1, sfrw_pkg::MODE_EXT, 16, {8'h00, sfrw_pkg::OP_WR_SR, 8'hFF});
		check("sr", 16'(regs.sr), 16'h00FC);
		check("sr_busy", 16'(bsy), 16'h0001);
		check("ready", 16'(pe_ready), 16'h0001);
		wr(1'b1, sfrw_pkg::MODE_QUAD, 24, {sfrw_pkg::OP_WR_NVCR, 16'h3412});
		check("nvcr", regs.nvcr, 16'h1234);
		$display("test timed writes done");
		wr(1'b0, sfrw_pkg::MODE_EXT, 16, {8'h00, sfrw_pkg::OP_WR_VCR, 8'h00});
		check("no_latch", 16'({dn, regs.vcr}), 16'(VEXP));
		wr(1'b1, sfrw_pkg::MODE_EXT, 12, {12'h000, sfrw_pkg::OP_WR_VCR, 4'h0});
		check("short", 16'({dn, regs.sr}), 16'h00FE);
		wp_n = 1'b0;
		repeat (4) @(negedge ref_clk);
		check("locked", 16'(hw_locked), 16'h0001);
		wr(1'b1, sfrw_pkg::MODE_EXT, 16, {8'h00, sfrw_pkg::OP_WR_SR, 8'h00});
		check("lock_sr", 16'({dn, regs.sr}), 16'h01FC);
		wp_n = 1'b1;
		wr(1'b1, sfrw_pkg::MODE_EXT, 16, {8'h00, sfrw_pkg::OP_WR_SR, 8'h00});
		check("open_sr", 16'({dn, regs.sr}), 16'h0100);
		$display("test refusals done");
		results;
	end

	// Watchdog that ends a hung run as a failure.
	initial begin
		#200000;
		errors++;
		results;
	end
endmodule
